// ===== core/ams_top.sv
// Purpose: anti-mask, supply and white-light supervisor with APB registers
// Assumes: ADC handshake on clk_in; jumpers and fault flags are pins
// Notes: tick period is a parameter so simulation can shorten it
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
`include "ams_cfg.svh"
module ams_top
	import ams_pkg::*;
#(
	parameter int unsigned TICK_CYC = `AMS_CLK_KHZ * `AMS_TICK_MS,
	parameter int unsigned DEB_N    = `AMS_DEB_DEF
) (
	input  wire logic        clk_in,          // 200 MHz
	input  wire logic        rstn_in,         // async, low
	input  wire logic        psel_in,         // apb select
	input  wire logic        penable_in,      // apb enable
	input  wire logic        pwrite_in,       // apb write
	input  wire logic [7:0]  paddr_in,        // byte address
	input  wire logic [31:0] pwdata_in,       // write data
	output logic      [31:0] prdata_out,      // read data
	output logic             pready_out,      // always ready
	output logic             pslverr_out,     // unmapped
	output logic             adc_req_out,     // start pulse
	output logic      [1:0]  adc_chan_out,    // channel
	input  wire logic        adc_done_in,     // result pulse
	input  wire logic [11:0] adc_data_in,     // result
	input  wire logic        pyro_fault_in,   // pin
	input  wire logic [2:0]  jumper_n_in,     // pulse, pet, led
	input  wire logic        status_led_in,   // engine led request
	output logic             status_led_pin_out, // led level
	output logic             status_led_pin_oe_out, // high = drive
	output logic             ir_emitter_drive_out,  // high = on
	output logic             trouble_output_out,    // relay
	output logic             trouble_led_out,       // yellow
	output logic             dc_shift_out,    // compensate pulse
	output logic             pulse_mode_out,  // jumper fitted
	output logic             pet_mode_out,    // jumper fitted
	output logic             led_auto_out,    // jumper fitted
	output logic             irq_out          // level
);
	localparam int TW = $clog2(TICK_CYC);

	// jumper and fault pins come from outside, two flops each
	logic [3:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_s1_q <= 4'hf;
			pin_s2_q <= 4'hf;
		end else begin
			pin_s1_q <= {~pyro_fault_in, jumper_n_in};
			pin_s2_q <= pin_s1_q;
		end
	end

	// 100 ms tick and mask phase
	logic [TW-1:0] tick_cnt_q, tick_cnt_d;
	logic          tick_q, tick_d;
	logic [1:0]    phase_q, phase_d;
	always_comb begin
		tick_cnt_d = tick_cnt_q + 1'b1;
		tick_d     = 1'b0;
		phase_d    = phase_q;
		if (tick_cnt_q == TW'(TICK_CYC - 1)) begin
			tick_cnt_d = '0;
			tick_d     = 1'b1;
			phase_d    = phase_q + 2'h1;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
			phase_q    <= 2'h0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q     <= tick_d;
			phase_q    <= phase_d;
		end
	end

	// multiplier table, entries are gain x16; dimmer ambient gets more margin
	function automatic logic [7:0] ams_mult(input logic [3:0] idx);
		logic [7:0] m;
		m = 8'h11;
		unique case (idx)
			4'h0: m = 8'h20;
			4'h1: m = 8'h1c;
			4'h2: m = 8'h1a;
			4'h3: m = 8'h18;
			4'h4: m = 8'h16;
			4'h5: m = 8'h15;
			4'h6: m = 8'h14;
			4'h7: m = 8'h13;
			default: m = 8'h12;
		endcase
		return m;
	endfunction : ams_mult

	// adc sequencer, shared converter serves three jobs
	ams_seq_t    st_q, st_d;
	logic [2:0]  pend_q, pend_d;
	logic        cmp_q, cmp_d;
	logic [2:0]  wl_cnt_q, wl_cnt_d;
	logic        req_q, req_d;
	logic [1:0]  chan_q, chan_d;
	logic        oe_q, oe_d;
	logic [1:0]  ctrl_q, ctrl_d;
	always_comb begin
		st_d     = st_q;
		pend_d   = pend_q;
		cmp_d    = cmp_q;
		wl_cnt_d = wl_cnt_q;
		req_d    = 1'b0;
		chan_d   = chan_q;
		oe_d     = oe_q;
		if (tick_q) begin
			pend_d[1] = 1'b1;
			if (phase_q == `AMS_PH_BASE || phase_q == `AMS_PH_CMP) begin
				pend_d[0] = 1'b1;
				cmp_d     = (phase_q == `AMS_PH_CMP);
			end
			wl_cnt_d = wl_cnt_q + 3'h1;
			if (wl_cnt_q == `AMS_WL_TICKS - 3'h1) begin
				wl_cnt_d  = 3'h0;
				pend_d[2] = ctrl_q[`AMS_CTRL_WL];
			end
		end
		unique case (st_q)
			AMS_IDLE: begin
				if (pend_q[0]) begin
					st_d      = AMS_PD;
					pend_d[0] = 1'b0;
					req_d     = 1'b1;
					chan_d    = AMS_CH_PD;
				end else if (pend_q[1]) begin
					st_d      = AMS_SUP;
					pend_d[1] = 1'b0;
					req_d     = 1'b1;
					chan_d    = AMS_CH_SUP;
				end else if (pend_q[2]) begin
					st_d      = AMS_WL;
					pend_d[2] = 1'b0;
					req_d     = 1'b1;
					chan_d    = AMS_CH_LED;
					oe_d      = 1'b0;
				end
			end
			AMS_PD, AMS_SUP: begin
				if (adc_done_in) st_d = AMS_IDLE;
			end
			AMS_WL: begin
				if (adc_done_in) begin
					st_d = AMS_IDLE;
					oe_d = 1'b1;
				end
			end
		endcase
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q     <= AMS_IDLE;
			pend_q   <= 3'h0;
			cmp_q    <= 1'b0;
			wl_cnt_q <= 3'h0;
			req_q    <= 1'b0;
			chan_q   <= AMS_CH_PD;
			oe_q     <= 1'b1;
		end else begin
			st_q     <= st_d;
			pend_q   <= pend_d;
			cmp_q    <= cmp_d;
			wl_cnt_q <= wl_cnt_d;
			req_q    <= req_d;
			chan_q   <= chan_d;
			oe_q     <= oe_d;
		end
	end

	// evaluation of results, emitter and fault flags
	logic        pd_done, sup_done, wl_done;
	logic [19:0] prod;
	logic [15:0] comp_q, comp_d;
	logic [11:0] thr_q, thr_d;
	logic [11:0] wl_last_q, wl_last_d;
	logic [11:0] wl_diff;
	logic [7:0]  deb_q, deb_d;
	logic        mask_q, mask_d, sup_q, sup_d, shift_q, shift_d;
	logic        emit_q, emit_d;
	assign pd_done  = (st_q == AMS_PD) && adc_done_in;
	assign sup_done = (st_q == AMS_SUP) && adc_done_in;
	assign wl_done  = (st_q == AMS_WL) && adc_done_in;
	assign prod     = adc_data_in * ams_mult(adc_data_in[11:8]);
	assign wl_diff  = (adc_data_in > wl_last_q) ? adc_data_in - wl_last_q
						: wl_last_q - adc_data_in;
	always_comb begin
		comp_d    = comp_q;
		deb_d     = deb_q;
		mask_d    = mask_q;
		sup_d     = sup_q;
		shift_d   = 1'b0;
		wl_last_d = wl_last_q;
		emit_d    = emit_q;
		if (tick_q && phase_q == `AMS_PH_BASE) emit_d = 1'b0;
		if (tick_q && phase_q == `AMS_PH_CMP) emit_d = 1'b1;
		if (pd_done && !cmp_q) comp_d = prod[19:`AMS_MULT_SHIFT];
		if (pd_done && cmp_q) begin
			if ({4'h0, adc_data_in} > comp_q) begin
				if (deb_q != 8'hff) deb_d = deb_q + 8'h1;
				if (deb_q + 8'h1 >= 8'(DEB_N)) mask_d = 1'b1;
			end else begin
				deb_d  = 8'h0;
				mask_d = 1'b0;
			end
		end
		if (sup_done) sup_d = (adc_data_in < thr_q);
		if (wl_done) begin
			wl_last_d = adc_data_in;
			shift_d   = (wl_diff > `AMS_WL_DELTA);
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			comp_q    <= 16'hffff;
			deb_q     <= 8'h0;
			mask_q    <= 1'b0;
			sup_q     <= 1'b0;
			shift_q   <= 1'b0;
			wl_last_q <= 12'h0;
			emit_q    <= 1'b0;
		end else begin
			comp_q    <= comp_d;
			deb_q     <= deb_d;
			mask_q    <= mask_d;
			sup_q     <= sup_d;
			shift_q   <= shift_d;
			wl_last_q <= wl_last_d;
			emit_q    <= emit_d;
		end
	end

	// pin outputs; pwm gates the emitter level when enabled
	logic [7:0] pwm_cnt_q, pwm_cnt_d;
	logic       pwm_ph_q, pwm_ph_d;
	logic       fault;
	logic       drv_q, trb_q, led_q, sled_q;
	assign fault = mask_q | sup_q | ~pin_s2_q[3];
	always_comb begin
		pwm_cnt_d = pwm_cnt_q + 8'h1;
		pwm_ph_d  = pwm_ph_q;
		if (pwm_cnt_q == `AMS_PWM_HALF - 8'h1) begin
			pwm_cnt_d = 8'h0;
			pwm_ph_d  = ~pwm_ph_q;
		end
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pwm_cnt_q <= 8'h0;
			pwm_ph_q  <= 1'b0;
			drv_q     <= 1'b0;
			trb_q     <= 1'b0;
			led_q     <= 1'b0;
			sled_q    <= 1'b0;
		end else begin
			pwm_cnt_q <= pwm_cnt_d;
			pwm_ph_q  <= pwm_ph_d;
			drv_q     <= emit_q & (~ctrl_q[`AMS_CTRL_PWM] | pwm_ph_q);
			trb_q     <= fault;
			led_q     <= fault;
			sled_q    <= status_led_in & oe_q;
		end
	end

	// apb slave: zero wait, read data caught in the setup cycle
	logic        setup, wr, rdclr, hit;
	logic [31:0] rd_q, rd_d;
	logic        err_q, err_d;
	logic [3:0]  ev, ist_q, ist_d, msk_q, msk_d;
	logic        irq_q;
	logic [28:0] calp;
	assign setup = psel_in & ~penable_in;
	assign wr    = psel_in & penable_in & pwrite_in;
	assign rdclr = psel_in & penable_in & ~pwrite_in && paddr_in == `AMS_A_IRQ;
	assign ev    = {~pin_s2_q[3], shift_q, sup_d & ~sup_q, mask_d & ~mask_q};
	assign calp  = 29'((`AMS_FULL_SCALE - {1'b0, pwdata_in[27:16]}) * pwdata_in[15:0]);
	always_comb begin
		hit = 1'b1;
		unique case (paddr_in)
			`AMS_A_CTRL: rd_d = {30'h0, ctrl_q};
			`AMS_A_STAT: rd_d = {22'h0, phase_q, ~pin_s2_q[2:0], ~pin_s2_q[3], sup_q,
					mask_q, trb_q, emit_q};
			`AMS_A_IRQ:  rd_d = {28'h0, ist_q};
			`AMS_A_MASK: rd_d = {28'h0, msk_q};
			`AMS_A_THR:  rd_d = {20'h0, thr_q};
			`AMS_A_BASE: rd_d = {16'h0, comp_q};
			`AMS_A_CAL:  rd_d = 32'h0;
			default: begin
				rd_d = 32'h0;
				hit  = 1'b0;
			end
		endcase
		err_d = setup ? ~hit : err_q;
		if (!setup) rd_d = rd_q;
		ctrl_d = ctrl_q;
		msk_d  = msk_q;
		thr_d  = thr_q;
		if (wr && paddr_in == `AMS_A_CTRL) ctrl_d = pwdata_in[1:0];
		if (wr && paddr_in == `AMS_A_MASK) msk_d = pwdata_in[3:0];
		if (wr && paddr_in == `AMS_A_THR) thr_d = pwdata_in[11:0];
		if (wr && paddr_in == `AMS_A_CAL) thr_d = 12'(calp / `AMS_VREF_MV);
		// only bits that were read are cleared, so a late event survives
		ist_d = (rdclr ? ist_q & ~rd_q[3:0] : ist_q) | ev;
	end
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_q   <= 32'h0;
			err_q  <= 1'b0;
			ctrl_q <= `AMS_CTRL_RST;
			msk_q  <= 4'h0;
			thr_q  <= `AMS_SUP_DEF;
			ist_q  <= 4'h0;
			irq_q  <= 1'b0;
		end else begin
			rd_q   <= rd_d;
			err_q  <= err_d;
			ctrl_q <= ctrl_d;
			msk_q  <= msk_d;
			thr_q  <= thr_d;
			ist_q  <= ist_d;
			irq_q  <= |(ist_q & msk_q);
		end
	end

	assign prdata_out            = rd_q;
	assign pready_out            = 1'b1;
	assign pslverr_out           = err_q;
	assign adc_req_out           = req_q;
	assign adc_chan_out          = chan_q;
	assign status_led_pin_out    = sled_q;
	assign status_led_pin_oe_out = oe_q;
	assign ir_emitter_drive_out  = drv_q;
	assign trouble_output_out    = trb_q;
	assign trouble_led_out       = led_q;
	assign dc_shift_out          = shift_q;
	assign pulse_mode_out        = ~pin_s2_q[0];
	assign pet_mode_out          = ~pin_s2_q[1];
	assign led_auto_out          = ~pin_s2_q[2];
	assign irq_out               = irq_q;

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	property p_phase_step;
		tick_q |-> phase_q == $past(phase_q) + 2'h1;
	endproperty
	a_phase_step: assert property (p_phase_step) else $error("phase not stepped");

	property p_base_off;
		tick_q && phase_q == `AMS_PH_BASE |=> !emit_q ##1 !drv_q;
	endproperty
	a_base_off: assert property (p_base_off) else $error("emitter on in base");

	property p_cmp_on;
		tick_q && phase_q == `AMS_PH_CMP && !ctrl_q[`AMS_CTRL_PWM] |=> emit_q ##1 drv_q;
	endproperty
	a_cmp_on: assert property (p_cmp_on) else $error("emitter off in compare");

	property p_comp_scale;
		pd_done && !cmp_q |=> comp_q == $past(prod) >> 4;
	endproperty
	a_comp_scale: assert property (p_comp_scale) else $error("baseline scale");

	property p_mask_cause;
		$rose(mask_q) |-> $past(pd_done && cmp_q && {4'h0, adc_data_in} > comp_q);
	endproperty
	a_mask_cause: assert property (p_mask_cause) else $error("mask without excess");

	property p_trouble;
		fault |=> trb_q && led_q;
	endproperty
	a_trouble: assert property (p_trouble) else $error("trouble not raised");

	property p_release;
		!fault |=> !trb_q && !led_q;
	endproperty
	a_release: assert property (p_release) else $error("trouble not released");

	property p_sup_low;
		sup_done && adc_data_in < thr_q |=> sup_q ##1 trb_q;
	endproperty
	a_sup_low: assert property (p_sup_low) else $error("supply low missed");

	property p_wl_pin;
		st_q == AMS_WL |-> !oe_q;
	endproperty
	a_wl_pin: assert property (p_wl_pin) else $error("led driven while sensing");
endmodule : ams_top

// ===== core/ams_cfg.svh
// Purpose: constants for the anti-mask and supply supervisor
// Assumes: 200 MHz system clock, APB register access
// Notes: addresses are byte offsets on the APB
`ifndef AMS_CFG_SVH
`define AMS_CFG_SVH
`define AMS_CLK_KHZ     200000
`define AMS_TICK_MS     100
`define AMS_PH_BASE     2'h1
`define AMS_PH_CMP      2'h3
`define AMS_MULT_SHIFT  4
`define AMS_SUP_DEF     12'h76c
`define AMS_FULL_SCALE  13'h0fff
`define AMS_VREF_MV     17'h007d0
`define AMS_DEB_DEF     2
`define AMS_WL_TICKS    3'h4
`define AMS_WL_DELTA    12'h040
`define AMS_PWM_HALF    8'h64
`define AMS_A_CTRL      8'h00
`define AMS_A_STAT      8'h04
`define AMS_A_IRQ       8'h08
`define AMS_A_MASK      8'h0c
`define AMS_A_THR       8'h10
`define AMS_A_CAL       8'h14
`define AMS_A_BASE      8'h18
`define AMS_CTRL_RST    2'h1
`define AMS_CTRL_WL     0
`define AMS_CTRL_PWM    1
`endif

// ===== core/ams_pkg.sv
// Purpose: shared types of the supervisor
// Assumes: one-hot sequencer states
// Notes: constants live in ams_cfg.svh
package ams_pkg;
	typedef enum logic [3:0] {
		AMS_IDLE = 4'h1,
		AMS_PD   = 4'h2,
		AMS_SUP  = 4'h4,
		AMS_WL   = 4'h8
	} ams_seq_t;
	typedef enum logic [1:0] {
		AMS_CH_PD  = 2'h0,
		AMS_CH_LED = 2'h1,
		AMS_CH_SUP = 2'h2
	} ams_chan_t;
endpackage : ams_pkg

// ===== tb/ams_adc_model.sv
// Purpose: adc with photodiode, supply and led sources for the supervisor
// Assumes: one conversion at a time, same clock as the block
// Notes: result lines toggle whenever no result is presented
`timescale 1ns/10ps
module ams_adc_model (
	input  wire logic        clk_in,      // system clock
	input  wire logic        rstn_in,     // async, low
	input  wire logic        req_in,      // start pulse
	input  wire logic [1:0]  chan_in,     // channel
	input  wire logic        emit_in,     // emitter drive
	input  wire logic        slow_in,     // stretch conversions
	input  wire logic [11:0] pd_off_in,   // dark level
	input  wire logic [11:0] pd_on_in,    // lit level
	input  wire logic [11:0] sup_in,      // supply count
	input  wire logic [11:0] led_in,      // led count
	output logic             done_out,    // result pulse
	output logic      [11:0] data_out,    // result
	output logic      [7:0]  pd_cnt_out,  // photodiode results
	output logic      [7:0]  on_cnt_out,  // of them lit
	output logic      [7:0]  led_cnt_out  // led results
);
	logic       pend_q;
	logic [1:0] ch_q;
	logic [2:0] wait_q;
	// the lit level shows only while the drive is high, sampled when the result lands
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pend_q      <= 1'b0;
			ch_q        <= 2'h0;
			wait_q      <= 3'h0;
			done_out    <= 1'b0;
			data_out    <= 12'h000;
			pd_cnt_out  <= 8'h00;
			on_cnt_out  <= 8'h00;
			led_cnt_out <= 8'h00;
		end else begin
			done_out <= 1'b0;
			data_out <= ~data_out;
			if (req_in) begin
				pend_q <= 1'b1;
				ch_q   <= chan_in;
				wait_q <= slow_in ? 3'h5 : 3'h0;
			end else if (pend_q && wait_q != 3'h0) begin
				wait_q <= wait_q - 3'h1;
			end else if (pend_q) begin
				pend_q   <= 1'b0;
				done_out <= 1'b1;
				if (ch_q == 2'h0) begin
					data_out   <= emit_in ? pd_on_in : pd_off_in;
					pd_cnt_out <= pd_cnt_out + 8'h01;
					on_cnt_out <= on_cnt_out + {7'h00, emit_in};
				end else if (ch_q == 2'h1) begin
					data_out    <= led_in;
					led_cnt_out <= led_cnt_out + 8'h01;
				end else begin
					data_out <= sup_in;
				end
			end
		end
	end
endmodule : ams_adc_model

// ===== tb/tb.sv
// Purpose: self-checking bench of the supervisor
// Assumes: short tick of 40 cycles, debounce of 2
// Notes: outputs are sampled at falling edges
`timescale 1ns/10ps
module tb;
	localparam int TICK = 40;
	logic        clk_in, rstn_in, psel, penable, pwrite, pready, err, pslverr, req, done;
	logic        pyro, led_pin, led_oe, emit, trouble, t_led, dc, pulse, pet, lauto, irq;
	logic        slow, sled;
	logic [7:0]  paddr, pd_n, on_n, led_n;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  chan;
	logic [2:0]  jmp_n;
	logic [11:0] adc_d, pd_off, pd_on, sup, led_v;
	int          bad_count, compares, cyc, n_oe, n_dc, n_em;

	ams_top #(.TICK_CYC(TICK), .DEB_N(2)) uut (.clk_in(clk_in), .rstn_in(rstn_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.adc_req_out(req), .adc_chan_out(chan), .adc_done_in(done), .adc_data_in(adc_d),
		.pyro_fault_in(pyro), .jumper_n_in(jmp_n), .status_led_in(sled),
		.status_led_pin_out(led_pin), .status_led_pin_oe_out(led_oe),
		.ir_emitter_drive_out(emit), .trouble_output_out(trouble), .trouble_led_out(t_led),
		.dc_shift_out(dc), .pulse_mode_out(pulse), .pet_mode_out(pet), .led_auto_out(lauto),
		.irq_out(irq));
	ams_adc_model adc (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req), .chan_in(chan),
		.emit_in(emit), .slow_in(slow), .pd_off_in(pd_off), .pd_on_in(pd_on), .sup_in(sup),
		.led_in(led_v), .done_out(done), .data_out(adc_d), .pd_cnt_out(pd_n),
		.on_cnt_out(on_n), .led_cnt_out(led_n));

	// free-running clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// a led conversion must find the pin released; also the hang limit
	always @(posedge clk_in) begin
		cyc++;
		if (!led_oe) n_oe++;
		if (dc) n_dc++;
		if (emit) n_em++;
		if (req && chan == 2'h1 && led_oe !== 1'b0) begin
			bad_count++;
			$display("Error led_oe expected 0 seen %b", led_oe);
		end
		if (cyc == 40000) begin
			bad_count++;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task automatic cy(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cy

	task automatic tk(input int n);
		cy(n * TICK);
	endtask : tk

	// setup cycle, then access held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		do @(posedge clk_in); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd & m);
	endtask : rchk

	task automatic t_reset;
		rchk("ctrl", 8'h00, 32'hffffffff, 32'h1);
		rchk("threshold", 8'h10, 32'hffffffff, 32'h76c);
		rchk("irq mask", 8'h0c, 32'hffffffff, 32'h0);
		rchk("baseline", 8'h18, 32'hffffffff, 32'hffff);
		chk("pslverr", 32'h0, {31'h0, err});
		rchk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
		chk("pslverr", 32'h1, {31'h0, err});
		$display("test reset done");
	endtask : t_reset

	task automatic t_period;
		logic [7:0] p, o;
		p = pd_n;
		o = on_n;
		tk(8);
		chk("pd conversions", 32'h4, {24'h0, 8'(pd_n - p)});
		chk("lit conversions", 32'h2, {24'h0, 8'(on_n - o)});
		$display("test period done");
	endtask : t_period

	// one lit excess alone must not be taken as a mask
	task automatic t_debounce;
		logic [7:0] o;
		o = on_n;
		@(posedge clk_in);
		pd_on <= 12'h0ff;
		while (on_n == o) @(posedge clk_in);
		pd_on <= 12'h010;
		// look right after the excess lands, before the next clean compare could hide it
		cy(4);
		chk("single excess", 32'h0, {31'h0, trouble});
		tk(12);
		chk("single excess", 32'h0, {31'h0, trouble});
		$display("test debounce done");
	endtask : t_debounce

	task automatic t_mask;
		@(posedge clk_in);
		slow  <= 1'b1;
		pd_on <= 12'h0ff;
		tk(12);
		chk("trouble", 32'h1, {31'h0, trouble});
		chk("trouble led", 32'h1, {31'h0, t_led});
		rchk("status mask", 8'h04, 32'h4, 32'h4);
		apb(1'b0, 8'h18, 32'h0);
		chk("baseline range", 32'h1, {31'h0, rd >= 32'h12 && rd <= 32'h20});
		@(posedge clk_in);
		pd_on <= 12'h010;
		tk(8);
		chk("trouble", 32'h0, {31'h0, trouble});
		chk("trouble led", 32'h0, {31'h0, t_led});
		$display("test mask done");
	endtask : t_mask

	task automatic t_supply;
		@(posedge clk_in);
		sup <= 12'h76b;
		tk(2);
		chk("trouble", 32'h1, {31'h0, trouble});
		chk("irq masked", 32'h0, {31'h0, irq});
		rchk("status supply", 8'h04, 32'h8, 32'h8);
		apb(1'b1, 8'h0c, 32'h2);
		cy(2);
		chk("irq", 32'h1, {31'h0, irq});
		rchk("irq status", 8'h08, 32'h2, 32'h2);
		cy(2);
		chk("irq cleared", 32'h0, {31'h0, irq});
		@(posedge clk_in);
		sup <= 12'h76c;
		tk(2);
		chk("trouble", 32'h0, {31'h0, trouble});
		$display("test supply done");
	endtask : t_supply

	task automatic t_pyro;
		@(posedge clk_in);
		pyro <= 1'b1;
		cy(8);
		chk("trouble", 32'h1, {31'h0, trouble});
		chk("trouble led", 32'h1, {31'h0, t_led});
		@(posedge clk_in);
		pyro <= 1'b0;
		cy(8);
		chk("trouble", 32'h0, {31'h0, trouble});
		$display("test pyro done");
	endtask : t_pyro

	task automatic t_jump;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_in);
			jmp_n <= ~(3'h1 << i);
			cy(4);
			chk("jumper", 32'(3'h1 << i), {29'h0, lauto, pet, pulse});
			rchk("status jumper", 8'h04, 32'he0, 32'(3'h1 << i) << 5);
		end
		apb(1'b1, 8'h14, 32'h00ff03e8);
		rchk("threshold", 8'h10, 32'hffffffff, 32'h780);
		$display("test jumper and cal done");
	endtask : t_jump

	task automatic t_light;
		logic [7:0] l;
		int         o, d;
		tk(8);
		l = led_n;
		o = n_oe;
		d = n_dc;
		@(posedge clk_in);
		led_v <= 12'h200;
		tk(8);
		chk("led conversions", 32'h2, {24'h0, 8'(led_n - l)});
		chk("pin released", 32'h1, {31'h0, n_oe > o});
		chk("shift pulses", 32'h1, 32'(n_dc - d));
		apb(1'b1, 8'h00, 32'h0);
		// a conversion queued by the last tick may still finish
		tk(1);
		l = led_n;
		tk(8);
		chk("led off", 32'h0, {24'h0, 8'(led_n - l)});
		$display("test light done");
	endtask : t_light

	// emitter is on for phases 3 and 0, half of every 4 ticks; pwm must chop it
	task automatic t_pwm;
		int e;
		e = n_em;
		tk(8);
		chk("emitter on cycles", 32'(4 * TICK), 32'(n_em - e));
		apb(1'b1, 8'h00, 32'h2);
		tk(1);
		e = n_em;
		tk(8);
		chk("pwm chops emitter", 32'h1, {31'h0, n_em - e > 0 && n_em - e < 4 * TICK});
		@(posedge clk_in);
		sled <= 1'b1;
		cy(2);
		chk("led pin", 32'h1, {31'h0, led_pin});
		@(posedge clk_in);
		sled <= 1'b0;
		cy(2);
		chk("led pin", 32'h0, {31'h0, led_pin});
		$display("test pwm done");
	endtask : t_pwm

	// inputs settle at time zero, reset held for 8 cycles
	initial begin
		rstn_in = 1'b0;
		{psel, penable, pwrite, pyro, slow} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		jmp_n = 3'h7;
		sled = 1'b0;
		{pd_off, pd_on, sup, led_v} = {12'h010, 12'h010, 12'h900, 12'h100};
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		t_reset();
		t_period();
		t_debounce();
		t_mask();
		t_supply();
		t_pyro();
		t_jump();
		t_light();
		t_pwm();
		complete_run();
	end
endmodule : tb
